// *** tb/cmt_can_node.sv ***
// behavioural model of the other nodes on the bus, acting as the transmit engine
`timescale 1ns/1ps

module cmt_can_node
  import cmt_pkg::*;
#(
  parameter int LAT = 6
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // control from the bench
  input wire logic i_take,
  input wire logic i_fail,
  // offer from the controller
  input wire cmt_pkg::cmt_tx_offer_s i_offer,
  // events back to the controller, send log and frame count for the bench
  output cmt_pkg::cmt_tx_event_s o_evt,
  output logic [29:0] o_log,
  output logic [7:0] o_n_end
);
  logic busy;
  logic [7:0] cnt;

  // ==========================================================================
  // take one offer, hold the frame for a while, then end it
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_evt <= '0;
      o_log <= '0;
      o_n_end <= '0;
      busy <= 1'b0;
      cnt <= '0;
    end
    else
    begin
      o_evt <= '0;
      if (!busy && cnt == 8'h00 && !o_evt.start && i_take && i_offer.valid)
      begin
        o_evt.start <= 1'b1;
        o_log <= {o_log[24:0], i_offer.mbox};
        busy <= 1'b1;
        cnt <= 8'(LAT);
      end
      else if (cnt != 8'h00)
      begin
        cnt <= cnt - 8'h01;
      end
      else if (busy)
      begin
        // lost arbitration or bus error when asked to fail
        o_evt.fail <= i_fail;
        o_evt.done <= !i_fail;
        o_n_end <= o_n_end + 8'h01;
        busy <= 1'b0;
        // gap so the controller settles its next pick
        cnt <= 8'h03;
      end
    end
  end
endmodule : cmt_can_node

// *** tb/tb.sv ***
// self-checking bench of the mailbox transmit-request control block
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      miscompares++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
    end \
  end

module tb;
  import cmt_pkg::*;

  typedef struct packed {
    logic w;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } cmt_row_s;

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  cmt_cpu_req_s cpu = '0;
  logic [31:0] rdata;
  cmt_tx_offer_s tx;
  cmt_tx_event_s evt;
  cmt_rx_remote_s rxr = '0;
  logic int0;
  logic int1;
  logic abort_flag;
  logic take = 1'b0;
  logic fail = 1'b0;
  logic [29:0] log_q;
  logic [7:0] n_end;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] got;
  cmt_row_s rows [0:9] = '{
    '{1'b0, OFS_ENABLE, 32'h0, 32'h0},
    '{1'b0, OFS_DIRECTION, 32'h0, 32'h0},
    '{1'b0, OFS_TX_REQ_SET, 32'h0, 32'h0},
    '{1'b0, OFS_REQ_CANCEL, 32'h0, 32'h0},
    '{1'b0, OFS_TX_ACK, 32'h0, 32'h0},
    '{1'b1, OFS_DIRECTION, 32'ha5a5a5a5, 32'ha5a5a5a5},
    '{1'b1, OFS_DIRECTION, 32'h0, 32'h0},
    '{1'b1, OFS_ENABLE, 32'h00000028, 32'h00000028},
    '{1'b1, 12'h040, 32'hffffffff, 32'h0},
    '{1'b1, OFS_TX_ACK, 32'hffffffff, 32'h0}
  };

  always #5 sys_clk = ~sys_clk;

  cmt_mailbox_ctrl u_dut (
    .i_sys_clk(sys_clk),
    .i_arst_n(arst_n),
    .i_cpu(cpu),
    .o_cpu_rdata(rdata),
    .o_tx(tx),
    .i_tx_evt(evt),
    .i_rx_remote(rxr),
    .o_mbox_int0(int0),
    .o_mbox_int1(int1),
    .o_abort_flag(abort_flag)
  );

  cmt_can_node #(.LAT(6)) u_node (
    .i_sys_clk(sys_clk),
    .i_arst_n(arst_n),
    .i_take(take),
    .i_fail(fail),
    .i_offer(tx),
    .o_evt(evt),
    .o_log(log_q),
    .o_n_end(n_end)
  );

  // ==========================================================================
  // closing report
  task automatic complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // register bus cycles, frame count wait and test end note
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cpu <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    cpu.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    cpu <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    cpu.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic wait_end(input logic [7:0] n);
    int k;
    for (k = 0; k < 300 && n_end !== n; k++)
    begin
      @(posedge sys_clk);
    end
    if (n_end !== n)
    begin
      miscompares++;
      $display("wrong value frame count exp %h got %h", n, n_end);
      complete_run();
    end
    #1;
  endtask : wait_end

  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask : endt

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 10; i++)
    begin
      if (rows[i].w)
      begin
        wr(rows[i].addr, rows[i].wdata);
      end
      rd(rows[i].addr, got);
      // reset and access of per-mailbox registers
      `CHK("register row", rows[i].exp, got)
    end
    endt("registers");

    wr(OFS_INT_MASK, 32'h00000020);
    take <= 1'b1;
    wr(OFS_TX_REQ_SET, 32'h00000028);
    wait_end(8'd2);
    `CHK("send order", {5'd5, 5'd3}, log_q[9:0])
    rd(OFS_TX_REQ_SET, got);
    `CHK("request after send", 32'h0, got)
    rd(OFS_TX_ACK, got);
    `CHK("ack after send", 32'h00000028, got)
    `CHK("mailbox flag line0", 1'b1, int0)
    `CHK("mailbox flag line1", 1'b0, int1)
    wr(OFS_TX_ACK, 32'h00000020);
    wr(OFS_TX_ACK, 32'h0);
    rd(OFS_TX_ACK, got);
    `CHK("ack after clear", 32'h00000008, got)
    `CHK("flag after clear", 1'b0, int0)
    endt("send");

    take <= 1'b0;
    wr(OFS_TX_REQ_SET, 32'h00000008);
    rd(OFS_TX_REQ_SET, got);
    `CHK("request pending", 32'h00000008, got)
    wr(OFS_REQ_CANCEL, 32'h00000008);
    rd(OFS_TX_REQ_SET, got);
    `CHK("request cancelled", 32'h0, got)
    rd(OFS_REQ_CANCEL, got);
    `CHK("cancel cleared", 32'h0, got)
    rd(OFS_ABORT_ACK, got);
    `CHK("abort ack", 32'h00000008, got)
    `CHK("abort flag", 1'b1, abort_flag)
    endt("cancel");

    fail <= 1'b1;
    take <= 1'b1;
    wr(OFS_TX_REQ_SET, 32'h00000020);
    wait_end(8'd3);
    fail <= 1'b0;
    wait_end(8'd4);
    `CHK("retried mailbox", 5'd5, log_q[4:0])
    rd(OFS_TX_REQ_SET, got);
    `CHK("request after retry", 32'h0, got)
    rd(OFS_TX_ACK, got);
    `CHK("ack after retry", 32'h00000028, got)
    endt("retry");

    take <= 1'b0;
    @(posedge sys_clk);
    rxr <= '{valid: 1'b1, mbox: 5'd3};
    @(posedge sys_clk);
    rxr <= '0;
    rd(OFS_TX_REQ_SET, got);
    `CHK("remote sets request", 32'h00000008, got)
    wr(OFS_TX_REQ_SET, 32'h00000001);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("offer valid", 1'b1, tx.valid)
    `CHK("offer skips disabled", 5'd3, tx.mbox)
    endt("remote");

    // identifier lock and offered identifier
    wr(OFS_ID_BASE + 12'h00c, 32'h0abcdef0);
    rd(OFS_ID_BASE + 12'h00c, got);
    `CHK("locked identifier", 32'h0, got)
    wr(OFS_ID_BASE, 32'h0abcdef0);
    rd(OFS_ID_BASE, got);
    `CHK("free identifier", 32'h0abcdef0, got)
    `CHK("offer id", 29'h0, tx.id)
    endt("identifier");

    // extended mode: priority level beats mailbox number
    wr(OFS_TPL_BASE + 12'h00c, 32'h00000001);
    wr(OFS_CONTROL, 32'h00000001);
    wr(OFS_TX_REQ_SET, 32'h00000020);
    take <= 1'b1;
    wait_end(8'd6);
    `CHK("priority order", {5'd3, 5'd5}, log_q[9:0])
    endt("priority");

    complete_run();
  end

  initial
  begin
    #200000;
    miscompares++;
    $display("wrong value run time exp %h got %h", 1'b0, 1'b1);
    complete_run();
  end
endmodule : tb

// *** verilog/cmt_mailbox_ctrl.sv ***
// mailbox enable, direction, transmit request, cancel and acknowledge control
`timescale 1ns/1ps

// Function
// - one enable bit per mailbox, all cleared at reset.
// - disabled mailboxes are never offered for transmission; storage stays cpu accessible.
// - identifier writes are refused while the mailbox is enabled.
// - direction bit 1 means receive, 0 transmit; cleared at reset.
// - writing 1 sets a transmit request bit; 0 does nothing; reset clears.
// - request bit clears on successful send or abort.
// - receive mailbox request only counts with remote request bit set.
// - a received remote frame request may set a request bit.
// - cpu set beats controller clear of a request bit.
// - pending requests go out one by one, highest mailbox number first.
// - cancel bits set only by cpu, cleared by logic on success or abort.
// - cancel withdraws a pending request not currently on the bus.
// - a frame in progress is not stopped; cancel clears at its end.
// - abort sets abort ack bit, success sets transmit ack bit.
// - cpu set beats internal clear of a cancel bit.
// - cancellation visible by reading the request bit.
// - transmit ack bit with mask set raises the mailbox interrupt flag.
// - writing 1 clears an ack bit and its interrupt; reset clears.
// - controller set beats cpu clear of an ack bit.
// - extended mode orders by priority level, then mailbox number.
// - failed frame retries after re-evaluating all pending requests.
// - abort also sets the global abort flag, cleared by writing 1.
module cmt_mailbox_ctrl (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // cpu register port
  input wire cmt_pkg::cmt_cpu_req_s i_cpu,
  output logic [31:0] o_cpu_rdata,
  // transmit engine side
  output cmt_pkg::cmt_tx_offer_s o_tx,
  input wire cmt_pkg::cmt_tx_event_s i_tx_evt,
  input wire cmt_pkg::cmt_rx_remote_s i_rx_remote,
  // flags
  output logic o_mbox_int0,
  output logic o_mbox_int1,
  output logic o_abort_flag
);
  import cmt_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [31:0] ena;
    logic [31:0] dir;
    logic [31:0] transmit_request_bit;
    logic [31:0] request_cancel_bit;
    logic [31:0] ta;
    logic [31:0] aa;
    logic [31:0] remote_request_bit;
    logic [31:0] mim;
    logic [31:0] mil;
    logic abort_global_flag;
    logic ext;
    cmt_fsm_e fsm;
    logic [4:0] act;
    logic [4:0] sel;
    logic [31:0] rdata;
    logic [NUM_MBOX-1:0][ID_W-1:0] id;
    logic [NUM_MBOX-1:0][TPL_W-1:0] transmit_priority_level;
  } cmt_state_s;

  cmt_state_s st;
  cmt_state_s next_st;
  logic rst_meta_n;
  logic rst_n;

  // ==========================================================================
  // reset release
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ==========================================================================
  // helpers
  // highest key wins; ties go to the higher mailbox number
  function automatic logic [5:0] pick_mbox(input logic [31:0] elig,
                                           input logic [NUM_MBOX-1:0][TPL_W-1:0] transmit_priority_level,
                                           input logic ext);
    logic found;
    logic [4:0] best;
    logic [TPL_W-1:0] best_key;
    logic [TPL_W-1:0] key;
    found = 1'b0;
    best = 5'h00;
    best_key = '0;
    for (int n = 0; n < NUM_MBOX; n++)
    begin
      key = ext ? transmit_priority_level[n] : '0;
      if (elig[n] && (!found || key >= best_key))
      begin
        found = 1'b1;
        best = 5'(n);
        best_key = key;
      end
    end
    return {found, best};
  endfunction : pick_mbox

  function automatic logic [31:0] onehot(input logic [4:0] idx);
    return 32'h0000_0001 << idx;
  endfunction : onehot

  // ==========================================================================
  // combinational terms
  logic wr_trs;
  logic wr_trr;
  logic wr_ta;
  logic wr_aa;
  logic [31:0] elig;
  logic [5:0] pick;
  logic busy;
  logic done_ok;
  logic fail_any;
  logic abort_now;
  logic [31:0] act_bit;
  logic [31:0] cancel_now;
  logic [31:0] remote_set;
  logic in_id;
  logic in_tpl;
  logic [4:0] tbl_idx;

  assign wr_trs = i_cpu.wr && (i_cpu.addr == OFS_TX_REQ_SET);
  assign wr_trr = i_cpu.wr && (i_cpu.addr == OFS_REQ_CANCEL);
  assign wr_ta = i_cpu.wr && (i_cpu.addr == OFS_TX_ACK);
  assign wr_aa = i_cpu.wr && (i_cpu.addr == OFS_ABORT_ACK);
  assign busy = (st.fsm == CMT_BUSY);
  assign act_bit = onehot(st.act);
  assign done_ok = busy && i_tx_evt.done;
  assign fail_any = busy && i_tx_evt.fail;
  // a failed frame whose cancel bit is up becomes an abort
  assign abort_now = fail_any && st.request_cancel_bit[st.act];
  assign elig = st.transmit_request_bit & st.ena & (~st.dir | st.remote_request_bit);
  assign pick = pick_mbox(elig, st.transmit_priority_level, st.ext);
  assign cancel_now = st.request_cancel_bit & st.transmit_request_bit & ~(busy ? act_bit : 32'h0000_0000);
  assign remote_set = (i_rx_remote.valid && st.ena[i_rx_remote.mbox] &&
                       !st.dir[i_rx_remote.mbox]) ? onehot(i_rx_remote.mbox) : 32'h0000_0000;
  assign in_id = (i_cpu.addr >= OFS_ID_BASE) && (i_cpu.addr < OFS_ID_BASE + OFS_TABLE_SPAN);
  assign in_tpl = (i_cpu.addr >= OFS_TPL_BASE) && (i_cpu.addr < OFS_TPL_BASE + OFS_TABLE_SPAN);
  assign tbl_idx = i_cpu.addr[6:2];

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [31:0] trs_clr;
    logic [31:0] trr_clr;
    logic [31:0] ta_set;
    logic [31:0] aa_set;
    trs_clr = cancel_now;
    trr_clr = cancel_now;
    ta_set = 32'h0000_0000;
    aa_set = cancel_now;
    next_st = st;
    next_st.rdata = 32'h0000_0000;

    if (done_ok)
    begin
      trs_clr = trs_clr | act_bit;
      trr_clr = trr_clr | act_bit;
      ta_set = act_bit;
    end
    if (abort_now)
    begin
      trs_clr = trs_clr | act_bit;
      trr_clr = trr_clr | act_bit;
      aa_set = aa_set | act_bit;
    end

    next_st.transmit_request_bit = (st.transmit_request_bit & ~trs_clr) | remote_set | (wr_trs ? i_cpu.wdata : 32'h0000_0000);
    next_st.request_cancel_bit = (st.request_cancel_bit & ~trr_clr) | (wr_trr ? i_cpu.wdata : 32'h0000_0000);
    next_st.ta = (st.ta & ~(wr_ta ? i_cpu.wdata : 32'h0000_0000)) | ta_set;
    next_st.aa = (st.aa & ~(wr_aa ? i_cpu.wdata : 32'h0000_0000)) | aa_set;
    if (i_cpu.wr && (i_cpu.addr == OFS_GLOBAL_FLAG0) && i_cpu.wdata[BIT_ABORT_FLAG])
    begin
      next_st.abort_global_flag = 1'b0;
    end
    if (|aa_set)
    begin
      next_st.abort_global_flag = 1'b1;
    end

    // plain read/write registers
    if (i_cpu.wr)
    begin
      if (i_cpu.addr == OFS_ENABLE)
      begin
        next_st.ena = i_cpu.wdata;
      end
      else if (i_cpu.addr == OFS_DIRECTION)
      begin
        next_st.dir = i_cpu.wdata;
      end
      else if (i_cpu.addr == OFS_REMOTE_REQ)
      begin
        next_st.remote_request_bit = i_cpu.wdata;
      end
      else if (i_cpu.addr == OFS_INT_MASK)
      begin
        next_st.mim = i_cpu.wdata;
      end
      else if (i_cpu.addr == OFS_INT_LEVEL)
      begin
        next_st.mil = i_cpu.wdata;
      end
      else if (i_cpu.addr == OFS_CONTROL)
      begin
        next_st.ext = i_cpu.wdata[BIT_EXT_MODE];
      end
      else if (in_id && !st.ena[tbl_idx])
      begin
        next_st.id[tbl_idx] = i_cpu.wdata[ID_W-1:0];
      end
      else if (in_tpl)
      begin
        next_st.transmit_priority_level[tbl_idx] = i_cpu.wdata[TPL_W-1:0];
      end
    end

    // read data, valid only in the cycle after the strobe
    if (i_cpu.rd)
    begin
      if (i_cpu.addr == OFS_ENABLE)
      begin
        next_st.rdata = st.ena;
      end
      else if (i_cpu.addr == OFS_DIRECTION)
      begin
        next_st.rdata = st.dir;
      end
      else if (i_cpu.addr == OFS_TX_REQ_SET)
      begin
        next_st.rdata = st.transmit_request_bit;
      end
      else if (i_cpu.addr == OFS_REQ_CANCEL)
      begin
        next_st.rdata = st.request_cancel_bit;
      end
      else if (i_cpu.addr == OFS_TX_ACK)
      begin
        next_st.rdata = st.ta;
      end
      else if (i_cpu.addr == OFS_ABORT_ACK)
      begin
        next_st.rdata = st.aa;
      end
      else if (i_cpu.addr == OFS_REMOTE_REQ)
      begin
        next_st.rdata = st.remote_request_bit;
      end
      else if (i_cpu.addr == OFS_INT_MASK)
      begin
        next_st.rdata = st.mim;
      end
      else if (i_cpu.addr == OFS_INT_LEVEL)
      begin
        next_st.rdata = st.mil;
      end
      else if (i_cpu.addr == OFS_GLOBAL_FLAG0)
      begin
        next_st.rdata[BIT_MBOX_FLAG] = o_mbox_int0;
        next_st.rdata[BIT_ABORT_FLAG] = st.abort_global_flag;
      end
      else if (i_cpu.addr == OFS_GLOBAL_FLAG1)
      begin
        next_st.rdata[BIT_MBOX_FLAG] = o_mbox_int1;
      end
      else if (i_cpu.addr == OFS_CONTROL)
      begin
        next_st.rdata[BIT_EXT_MODE] = st.ext;
      end
      else if (i_cpu.addr == OFS_STATUS)
      begin
        next_st.rdata[BIT_BUSY] = busy;
        next_st.rdata[POS_ACTIVE +: 5] = st.act;
      end
      else if (in_id)
      begin
        next_st.rdata[ID_W-1:0] = st.id[tbl_idx];
      end
      else if (in_tpl)
      begin
        next_st.rdata[TPL_W-1:0] = st.transmit_priority_level[tbl_idx];
      end
    end

    // transmit sequencing
    case (st.fsm)
      CMT_IDLE:
      begin
        if (pick[5])
        begin
          next_st.sel = pick[4:0];
          next_st.fsm = CMT_OFFER;
        end
      end
      CMT_OFFER:
      begin
        if (o_tx.valid && i_tx_evt.start)
        begin
          next_st.act = st.sel;
          next_st.fsm = CMT_BUSY;
        end
        else if (pick[5])
        begin
          next_st.sel = pick[4:0];
        end
        else
        begin
          next_st.fsm = CMT_IDLE;
        end
      end
      CMT_BUSY:
      begin
        if (done_ok || fail_any)
        begin
          next_st.fsm = CMT_IDLE;
        end
      end
      default:
      begin
        next_st.fsm = CMT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.fsm <= CMT_IDLE;
      st.ena <= RST_BITS;
      st.dir <= RST_BITS;
      st.transmit_request_bit <= RST_BITS;
      st.ta <= RST_BITS;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign o_cpu_rdata = st.rdata;
  // offer is withdrawn at once if the chosen request vanishes
  assign o_tx.valid = (st.fsm == CMT_OFFER) && elig[st.sel];
  assign o_tx.mbox = st.sel;
  assign o_tx.id = st.id[st.sel];
  assign o_tx.remote = st.dir[st.sel];
  assign o_mbox_int0 = |(st.ta & st.mim & ~st.mil);
  assign o_mbox_int1 = |(st.ta & st.mim & st.mil);
  assign o_abort_flag = st.abort_global_flag;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_trs_set_wins: assert property (
    wr_trs |=> ((st.transmit_request_bit & $past(i_cpu.wdata)) == $past(i_cpu.wdata)))
    else $error("written request bit not set");
  a_ta_on_done: assert property (
    done_ok |=> st.ta[$past(st.act)] && !st.transmit_request_bit[$past(st.act)] == !$past(wr_trs &&
      i_cpu.wdata[st.act]) && st.fsm == CMT_IDLE)
    else $error("success not acknowledged");
  a_ta_clear_w1c: assert property (
    (wr_ta && !done_ok) |=> ((st.ta & $past(i_cpu.wdata)) == 32'h0000_0000))
    else $error("ack bit not cleared by write");
  a_id_locked: assert property (
    (i_cpu.wr && in_id && st.ena[tbl_idx]) |=> $stable(st.id))
    else $error("identifier changed while enabled");
  a_offer_enabled: assert property (
    o_tx.valid |-> st.ena[o_tx.mbox] && st.transmit_request_bit[o_tx.mbox])
    else $error("disabled or idle mailbox offered");
  a_rx_needs_rtr: assert property (
    o_tx.valid |-> (!st.dir[o_tx.mbox] || st.remote_request_bit[o_tx.mbox]))
    else $error("receive mailbox offered without remote bit");
  a_cancel_idle: assert property (
    ((|cancel_now) && !wr_trs && !i_rx_remote.valid) |=>
      ((st.transmit_request_bit & $past(cancel_now)) == 32'h0000_0000) && ((st.aa & $past(cancel_now)) != 0))
    else $error("cancel did not withdraw request");
  a_abort_flags: assert property (
    abort_now |=> st.abort_global_flag && st.aa[$past(st.act)] ##1 o_abort_flag || !st.abort_global_flag)
    else $error("abort flag not raised");
  a_busy_kept: assert property (
    (busy && !i_tx_evt.done && !i_tx_evt.fail) |=> busy && $stable(st.act))
    else $error("frame in progress dropped");
  a_int_follows: assert property (
    (done_ok && st.mim[st.act] && !st.mil[st.act]) |=> o_mbox_int0)
    else $error("mailbox interrupt not raised");

endmodule : cmt_mailbox_ctrl

// *** verilog/cmt_pkg.sv ***
// shared constants and types for the mailbox transmit-request control block
package cmt_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_MBOX = 32;
  localparam int unsigned ID_W = 29;
  localparam int unsigned TPL_W = 5;
  localparam int unsigned ADDR_W = 12;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_ENABLE = 12'h000;
  localparam logic [11:0] OFS_DIRECTION = 12'h004;
  localparam logic [11:0] OFS_TX_REQ_SET = 12'h008;
  localparam logic [11:0] OFS_REQ_CANCEL = 12'h00c;
  localparam logic [11:0] OFS_TX_ACK = 12'h010;
  localparam logic [11:0] OFS_ABORT_ACK = 12'h014;
  localparam logic [11:0] OFS_REMOTE_REQ = 12'h018;
  localparam logic [11:0] OFS_INT_MASK = 12'h01c;
  localparam logic [11:0] OFS_INT_LEVEL = 12'h020;
  localparam logic [11:0] OFS_GLOBAL_FLAG0 = 12'h024;
  localparam logic [11:0] OFS_GLOBAL_FLAG1 = 12'h028;
  localparam logic [11:0] OFS_CONTROL = 12'h02c;
  localparam logic [11:0] OFS_STATUS = 12'h030;
  localparam logic [11:0] OFS_ID_BASE = 12'h100;
  localparam logic [11:0] OFS_TPL_BASE = 12'h200;
  localparam logic [11:0] OFS_TABLE_SPAN = 12'h080;

  // ==========================================================================
  // field positions
  localparam int unsigned BIT_ABORT_FLAG = 14;
  localparam int unsigned BIT_MBOX_FLAG = 15;
  localparam int unsigned BIT_EXT_MODE = 0;
  localparam int unsigned BIT_BUSY = 0;
  localparam int unsigned POS_ACTIVE = 8;

  // ==========================================================================
  // reset values
  localparam logic [31:0] RST_BITS = 32'h0000_0000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    CMT_IDLE = 2'b00,
    CMT_OFFER = 2'b01,
    CMT_BUSY = 2'b11
  } cmt_fsm_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cmt_cpu_req_s;

  typedef struct packed {
    logic valid;
    logic [4:0] mbox;
    logic [ID_W-1:0] id;
    logic remote;
  } cmt_tx_offer_s;

  typedef struct packed {
    logic start;
    logic done;
    logic fail;
  } cmt_tx_event_s;

  typedef struct packed {
    logic valid;
    logic [4:0] mbox;
  } cmt_rx_remote_s;

endpackage : cmt_pkg
